/* rtl/iamrb_consts.vh */
`ifndef IAMRB_CONSTS_VH
`define IAMRB_CONSTS_VH
// ==========================================================
// direct register offsets
`define IAMRB_ADR_NULL      6'h00
`define IAMRB_ADR_WR_TGT    6'h01
`define IAMRB_ADR_WR_HI     6'h02
`define IAMRB_ADR_WR_LO     6'h03
`define IAMRB_ADR_WR_CS     6'h04
`define IAMRB_ADR_RD_TGT    6'h05
`define IAMRB_ADR_RD_CS     6'h06
`define IAMRB_ADR_RD_HI     6'h07
`define IAMRB_ADR_RD_LO     6'h08
`define IAMRB_ADR_SIN_S     6'h09
`define IAMRB_ADR_COS_S     6'h0A
`define IAMRB_ADR_TEMP_S    6'h0B
`define IAMRB_ADR_SIN_P     6'h0C
`define IAMRB_ADR_PRIM_ANG  6'h10
`define IAMRB_ADR_SEC_ANG   6'h19
`define IAMRB_ADR_SEC_SNAP  6'h1A
`define IAMRB_ADR_TP_SNAP   6'h1B
`define IAMRB_ADR_TURNS_S   6'h1C
`define IAMRB_ADR_TS_SNAP   6'h1D
`define IAMRB_ADR_ACCESS    6'h1E
`define IAMRB_ADR_ECHO      6'h1F
// ==========================================================
// control and status field positions
`define IAMRB_LAUNCH_BIT    15
`define IAMRB_BUSY_BIT      8
`define IAMRB_DONE_BIT      0
// serial frame layout
`define IAMRB_FRM_WR_BIT    31
`define IAMRB_FRM_ADR_HI    29
`define IAMRB_FRM_ADR_LO    24
// ==========================================================
// extended space ranges
`define IAMRB_EE_LAST       8'h3F
`define IAMRB_SHADOW_LAST   8'h7F
`define IAMRB_MISC_LAST     8'h9E
`define IAMRB_EXT_DEPTH     159
// ==========================================================
// reset values and timing
`define IAMRB_RST_WORD16    16'h0000
`define IAMRB_RST_BYTE      8'h00
`define IAMRB_CLK_NS        5
`define IAMRB_EE_WR_NS      6500000
`define IAMRB_EE_RD_NS      2000
// the same two times as clock counts at the 5 ns clock
`define IAMRB_EE_WR_CYC     21'h13_D620
`define IAMRB_EE_RD_CYC     21'h00_0190
`endif

/* rtl/iamrb_ext_mem.v */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// extended word store, registered read
module iamrb_ext_mem #(
  parameter DEPTH = 159,
  parameter AW    = 8,
  parameter DW    = 32
) (
  input  wire          clk_sys_in,
  input  wire          reset_n_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  input  wire          rd_en_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out
);
  reg [DW-1:0] mem_r [0:DEPTH-1]; // storage, not reset

  // write port; addresses past the end are dropped
  always @(posedge clk_sys_in) begin
    if (wr_en_in && (wr_addr_in < DEPTH)) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  // read port; holds until next read enable
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= {DW{1'b0}};
    end else if (rd_en_in) begin
      if (rd_addr_in < DEPTH) begin
        rd_data_out <= mem_r[rd_addr_in];
      end else begin
        rd_data_out <= {DW{1'b0}}; // unmapped reads zero
      end
    end
  end
endmodule // iamrb_ext_mem
`default_nettype wire

/* rtl/iamrb_spi_slave.v */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// serial port slave, mode 0, msb first, oversampled
module iamrb_spi_slave #(
  parameter FRAME_W = 32
) (
  input  wire               clk_sys_in,
  input  wire               reset_n_in,
  input  wire               sck_in,
  input  wire               cs_n_in,
  input  wire               mosi_in,
  input  wire [FRAME_W-1:0] tx_word_in,
  output reg                miso_out,
  output reg                miso_oe_out,
  output reg  [FRAME_W-1:0] rx_word_out,
  output reg                rx_valid_out
);
  reg               sck_s1, sck_s2, sck_s3; // sck sync + edge
  reg               cs_s1, cs_s2, cs_s3;    // select sync + edge
  reg               mosi_s1, mosi_s2;       // data sync
  reg [FRAME_W-1:0] rx_sh_r;                // incoming bits
  reg [FRAME_W-1:0] tx_sh_r;                // outgoing bits
  reg [6:0]         bit_cnt_r;              // bits taken

  wire sck_rise = sck_s2 & ~sck_s3;
  wire sck_fall = ~sck_s2 & sck_s3;
  wire cs_start = ~cs_s2 & cs_s3;
  wire cs_stop  = cs_s2 & ~cs_s3;

  // two-flop synchronisers, third stage for edges
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_s1 <= 1'b0; sck_s2 <= 1'b0; sck_s3 <= 1'b0;
      cs_s1 <= 1'b1; cs_s2 <= 1'b1; cs_s3 <= 1'b1;
      mosi_s1 <= 1'b0; mosi_s2 <= 1'b0;
    end else begin
      sck_s1 <= sck_in; sck_s2 <= sck_s1; sck_s3 <= sck_s2;
      cs_s1 <= cs_n_in; cs_s2 <= cs_s1; cs_s3 <= cs_s2;
      mosi_s1 <= mosi_in; mosi_s2 <= mosi_s1;
    end
  end

  // shift engine; short frames are thrown away
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_sh_r <= {FRAME_W{1'b0}};
      tx_sh_r <= {FRAME_W{1'b0}};
      bit_cnt_r <= 7'd0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
      rx_word_out <= {FRAME_W{1'b0}};
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      if (cs_start) begin
        tx_sh_r <= tx_word_in;
        miso_out <= tx_word_in[FRAME_W-1];
        miso_oe_out <= 1'b1;
        bit_cnt_r <= 7'd0;
      end else if (cs_stop) begin
        miso_oe_out <= 1'b0;
        if ({25'h000_0000, bit_cnt_r} == FRAME_W) begin
          rx_word_out <= rx_sh_r;
          rx_valid_out <= 1'b1;
        end
      end else if (!cs_s2 && sck_rise) begin
        rx_sh_r <= {rx_sh_r[FRAME_W-2:0], mosi_s2};
        bit_cnt_r <= bit_cnt_r + 7'd1;
      end else if (!cs_s2 && sck_fall) begin
        tx_sh_r <= {tx_sh_r[FRAME_W-2:0], 1'b0};
        miso_out <= tx_sh_r[FRAME_W-2];
      end
    end
  end
endmodule // iamrb_spi_slave
`default_nettype wire

/* rtl/iamrb_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "iamrb_consts.vh"
// ==========================================================
// indirect memory register bank, serial register port
module iamrb_top #(
  parameter        WR_CNT_W  = 21,
  parameter [20:0] EE_WR_CYC = `IAMRB_EE_WR_CYC,
  parameter        EXT_DEPTH = `IAMRB_EXT_DEPTH
) (
  input  wire        clk_sys_in,
  input  wire        reset_n_in,
  input  wire        spi_sck_in,
  input  wire        spi_cs_n_in,
  input  wire        spi_mosi_in,
  output wire        spi_miso_out,
  output wire        spi_miso_oe_out,
  input  wire [15:0] sin_s_in,
  input  wire [15:0] cos_s_in,
  input  wire [11:0] temp_s_in,
  input  wire [15:0] sin_p_in,
  input  wire [15:0] prim_angle_in,
  input  wire [15:0] secondary_angle_out_in,
  input  wire [15:0] turns_p_in,
  input  wire [15:0] turns_s_in,
  output reg  [15:0] turns_s_preset_out,
  output reg         turns_s_preset_stb_out,
  output reg  [15:0] access_word_out,
  output reg         access_stb_out
);
  // ========================================================
  // timing counts
  // eeprom fetch time in system clock cycles
  localparam [20:0] EE_RD_CYC =
    `IAMRB_EE_RD_CYC;
  localparam [20:0] CNT_ONE = 21'h00_0001; // cycle step
  localparam [20:0] CNT_ZERO = 21'h00_0000; // expiry mark

  // ========================================================
  // serial frame signals
  wire [31:0] frm_word;   // received frame
  wire        frm_valid;  // one-cycle frame strobe
  reg  [31:0] tx_word_r;  // reply for next frame
  wire        frm_wr;     // frame is a write
  wire [5:0]  frm_adr;    // direct address
  wire [15:0] frm_data;   // write data

  assign frm_wr   = frm_word[`IAMRB_FRM_WR_BIT];
  assign frm_adr  = frm_word[`IAMRB_FRM_ADR_HI:`IAMRB_FRM_ADR_LO];
  assign frm_data = frm_word[15:0];

  // slave shifts on the sampled link clock
  iamrb_spi_slave #(
    .FRAME_W (32)
  ) u_spi (
    .clk_sys_in   (clk_sys_in),
    .reset_n_in   (reset_n_in),
    .sck_in       (spi_sck_in),
    .cs_n_in      (spi_cs_n_in),
    .mosi_in      (spi_mosi_in),
    .tx_word_in   (tx_word_r),
    .miso_out     (spi_miso_out),
    .miso_oe_out  (spi_miso_oe_out),
    .rx_word_out  (frm_word),
    .rx_valid_out (frm_valid)
  );

  // ========================================================
  // decoded frame strobes
  wire wr_hit = frm_valid & frm_wr;        // any write frame
  wire rd_hit = frm_valid & ~frm_wr;       // any read frame
  wire wr_launch_req = wr_hit &
    (frm_adr == `IAMRB_ADR_WR_CS) &
    frm_data[`IAMRB_LAUNCH_BIT];
  wire rd_launch_req = wr_hit &
    (frm_adr == `IAMRB_ADR_RD_CS) &
    frm_data[`IAMRB_LAUNCH_BIT];

  // ========================================================
  // host-written registers
  reg [7:0]  wr_tgt_r;     // write target field
  reg [15:0] wr_hi_r;      // write bytes three, two
  reg [15:0] wr_lo_r;      // write bytes one, zero
  reg [7:0]  rd_tgt_r;     // read target field
  reg [15:0] echo_r;       // loopback scratch

  // plain storage; the null address has no storage at all
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_tgt_r <= `IAMRB_RST_BYTE;
      wr_hi_r  <= `IAMRB_RST_WORD16;
      wr_lo_r  <= `IAMRB_RST_WORD16;
      rd_tgt_r <= `IAMRB_RST_BYTE;
      echo_r   <= `IAMRB_RST_WORD16;
    end else if (wr_hit) begin
      case (frm_adr)
        `IAMRB_ADR_WR_TGT: begin
          wr_tgt_r <= frm_data[7:0];
        end
        `IAMRB_ADR_WR_HI: begin
          wr_hi_r <= frm_data;
        end
        `IAMRB_ADR_WR_LO: begin
          wr_lo_r <= frm_data;
        end
        `IAMRB_ADR_RD_TGT: begin
          rd_tgt_r <= frm_data[7:0];
        end
        `IAMRB_ADR_ECHO: begin
          echo_r <= frm_data;
        end
        default: begin
          // read-only, launch, null, strobe or reserved: nothing stored here
        end
      endcase
    end
  end

  // ========================================================
  // outward strobes: turns preset and access word
  // the unlock policy itself lives in the device controller
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      turns_s_preset_out     <= `IAMRB_RST_WORD16;
      turns_s_preset_stb_out <= 1'b0;
      access_word_out        <= `IAMRB_RST_WORD16;
      access_stb_out         <= 1'b0;
    end else begin
      turns_s_preset_stb_out <= 1'b0;
      access_stb_out         <= 1'b0;
      if (wr_hit && (frm_adr == `IAMRB_ADR_TURNS_S)) begin
        turns_s_preset_out     <= frm_data;
        turns_s_preset_stb_out <= 1'b1;
      end
      if (wr_hit && (frm_adr == `IAMRB_ADR_ACCESS)) begin
        access_word_out <= frm_data;
        access_stb_out  <= 1'b1;
      end
    end
  end

  // ========================================================
  // extended write engine
  reg                wr_busy_r;  // write busy flag
  reg                wr_done_r;  // write done flag
  reg [WR_CNT_W-1:0] wr_cnt_r;   // cycles left
  wire wr_start = wr_launch_req & ~wr_busy_r; // busy launch ignored
  wire wr_is_ee = (wr_tgt_r <= `IAMRB_EE_LAST);
  wire wr_mapped = (wr_tgt_r <= `IAMRB_MISC_LAST);
  wire mem_we = wr_start & wr_mapped;

  // word is committed at launch; the busy time models the cell
  // program time so the host sees the documented delay
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_busy_r <= 1'b0;
      wr_done_r <= 1'b0;
      wr_cnt_r  <= {WR_CNT_W{1'b0}};
    end else if (wr_start) begin
      wr_busy_r <= 1'b1;
      wr_done_r <= 1'b0;
      if (wr_is_ee) begin
        wr_cnt_r <= EE_WR_CYC - CNT_ONE;
      end else begin
        wr_cnt_r <= {WR_CNT_W{1'b0}};
      end
    end else if (wr_busy_r) begin
      if (wr_cnt_r == CNT_ZERO) begin
        wr_busy_r <= 1'b0;
        wr_done_r <= 1'b1;
      end else begin
        wr_cnt_r <= wr_cnt_r - CNT_ONE;
      end
    end
  end

  // ========================================================
  // extended read engine
  reg        rd_busy_r;  // read busy flag
  reg        rd_done_r;  // read done flag
  reg [20:0] rd_cnt_r;   // cycles left
  reg [31:0] rd_word_r;  // last completed read word
  wire [31:0] mem_rd_data; // memory output, stable after load
  wire rd_start = rd_launch_req & ~rd_busy_r;
  wire rd_is_ee = (rd_tgt_r <= `IAMRB_EE_LAST);

  // volatile reads wait one extra cycle for the registered
  // memory output; eeprom reads wait the full fetch time
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_busy_r <= 1'b0;
      rd_done_r <= 1'b0;
      rd_cnt_r  <= CNT_ZERO;
      rd_word_r <= 32'h0000_0000;
    end else if (rd_start) begin
      rd_busy_r <= 1'b1;
      rd_done_r <= 1'b0;
      if (rd_is_ee) begin
        rd_cnt_r <= EE_RD_CYC - CNT_ONE;
      end else begin
        rd_cnt_r <= CNT_ONE;
      end
    end else if (rd_busy_r) begin
      if (rd_cnt_r == CNT_ZERO) begin
        rd_busy_r <= 1'b0;
        rd_done_r <= 1'b1;
        rd_word_r <= mem_rd_data;
      end else begin
        rd_cnt_r <= rd_cnt_r - CNT_ONE;
      end
    end
  end

  // ========================================================
  // extended space storage
  iamrb_ext_mem #(
    .DEPTH (EXT_DEPTH),
    .AW    (8),
    .DW    (32)
  ) u_mem (
    .clk_sys_in  (clk_sys_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (wr_tgt_r),
    .wr_data_in  ({wr_hi_r, wr_lo_r}),
    .rd_en_in    (rd_start),
    .rd_addr_in  (rd_tgt_r),
    .rd_data_out (mem_rd_data)
  );

  // ========================================================
  // coherent snapshot on primary angle read
  reg [15:0] sec_snap_r;  // secondary angle snapshot
  reg [15:0] tp_snap_r;   // primary turns snapshot
  reg [15:0] ts_snap_r;   // secondary turns snapshot
  wire ang_read = rd_hit & (frm_adr == `IAMRB_ADR_PRIM_ANG);

  // all three taken in one edge so they agree with each other
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sec_snap_r <= `IAMRB_RST_WORD16;
      tp_snap_r  <= `IAMRB_RST_WORD16;
      ts_snap_r  <= `IAMRB_RST_WORD16;
    end else if (ang_read) begin
      sec_snap_r <= secondary_angle_out_in;
      tp_snap_r  <= turns_p_in;
      ts_snap_r  <= turns_s_in;
    end
  end

  // ========================================================
  // read-back multiplexer
  reg [15:0] rd_mux; // value at the frame's address

  // reserved and unmapped addresses read zero
  always @* begin
    rd_mux = `IAMRB_RST_WORD16;
    case (frm_adr)
      `IAMRB_ADR_NULL: begin
        rd_mux = `IAMRB_RST_WORD16;
      end
      `IAMRB_ADR_WR_TGT: begin
        rd_mux = {8'h00, wr_tgt_r};
      end
      `IAMRB_ADR_WR_HI: begin
        rd_mux = wr_hi_r;
      end
      `IAMRB_ADR_WR_LO: begin
        rd_mux = wr_lo_r;
      end
      `IAMRB_ADR_WR_CS: begin
        // launch bit always reads zero
        rd_mux[`IAMRB_BUSY_BIT] = wr_busy_r;
        rd_mux[`IAMRB_DONE_BIT] = wr_done_r;
      end
      `IAMRB_ADR_RD_TGT: begin
        rd_mux = {8'h00, rd_tgt_r};
      end
      `IAMRB_ADR_RD_CS: begin
        // launch bit always reads zero
        rd_mux[`IAMRB_BUSY_BIT] = rd_busy_r;
        rd_mux[`IAMRB_DONE_BIT] = rd_done_r;
      end
      `IAMRB_ADR_RD_HI: begin
        rd_mux = rd_word_r[31:16];
      end
      `IAMRB_ADR_RD_LO: begin
        rd_mux = rd_word_r[15:0];
      end
      `IAMRB_ADR_SIN_S: begin
        rd_mux = sin_s_in;
      end
      `IAMRB_ADR_COS_S: begin
        rd_mux = cos_s_in;
      end
      `IAMRB_ADR_TEMP_S: begin
        rd_mux = {4'h0, temp_s_in};
      end
      `IAMRB_ADR_SIN_P: begin
        rd_mux = sin_p_in;
      end
      `IAMRB_ADR_PRIM_ANG: begin
        rd_mux = prim_angle_in;
      end
      `IAMRB_ADR_SEC_ANG: begin
        rd_mux = secondary_angle_out_in;
      end
      `IAMRB_ADR_SEC_SNAP: begin
        rd_mux = sec_snap_r;
      end
      `IAMRB_ADR_TP_SNAP: begin
        rd_mux = tp_snap_r;
      end
      `IAMRB_ADR_TURNS_S: begin
        rd_mux = turns_s_in;
      end
      `IAMRB_ADR_TS_SNAP: begin
        rd_mux = ts_snap_r;
      end
      `IAMRB_ADR_ECHO: begin
        rd_mux = echo_r;
      end
      default: begin
        rd_mux = `IAMRB_RST_WORD16;        // access word too
      end
    endcase
  end

  // ========================================================
  // reply word for the following frame
  // reply is pipelined one frame: the host issues a read, the
  // next frame clocks out the value captured at its end
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_word_r <= 32'h0000_0000;
    end else if (rd_hit) begin
      tx_word_r <= {16'h0000, rd_mux};
    end else if (wr_hit) begin
      tx_word_r <= 32'h0000_0000;
    end
  end
endmodule // iamrb_top
`default_nettype wire

/* verification/iamrb_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the register bank
module iamrb_monitor (
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic        spi_cs_n_in,
  input wire logic        spi_miso_oe_out,
  input wire logic [15:0] turns_s_preset_out,
  input wire logic        turns_s_preset_stb_out,
  input wire logic [15:0] access_word_out,
  input wire logic        access_stb_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================
  // frame phases; six cycles covers the select synchroniser
  sequence s_cs_idle;
    spi_cs_n_in [*6];
  endsequence
  sequence s_cs_busy;
    !spi_cs_n_in [*6];
  endsequence
  a_oe_in_frame: assert property (s_cs_busy |-> spi_miso_oe_out)
    else $error("reply enable low inside a frame");
  a_oe_idle_low: assert property (s_cs_idle |-> !spi_miso_oe_out)
    else $error("reply enable high outside a frame");
  a_access_one_pulse: assert property (access_stb_out |=> !access_stb_out)
    else $error("access strobe longer than one cycle");
  a_preset_one_pulse: assert property (
    turns_s_preset_stb_out |=> !turns_s_preset_stb_out)
    else $error("preset strobe longer than one cycle");
  a_access_word_cause: assert property (
    $changed(access_word_out) |-> access_stb_out)
    else $error("access word moved without a write");
  a_preset_word_cause: assert property (
    $changed(turns_s_preset_out) |-> turns_s_preset_stb_out)
    else $error("preset word moved without a write");
  a_strobe_one_target: assert property (
    !(access_stb_out && turns_s_preset_stb_out))
    else $error("one write hit two registers");
  // a write acts only once its frame has closed
  a_strobe_after_frame: assert property (
    $rose(access_stb_out) |-> $past(spi_cs_n_in, 2) && $past(spi_cs_n_in, 3))
    else $error("access strobe inside a frame");
  a_reset_quiet: assert property (
    $rose(reset_n_in) |-> !spi_miso_oe_out && !access_stb_out)
    else $error("outputs active at reset release");
endmodule // iamrb_monitor
bind iamrb_top iamrb_monitor iamrb_monitor_i (
  .clk_sys_in             (clk_sys_in),
  .reset_n_in             (reset_n_in),
  .spi_cs_n_in            (spi_cs_n_in),
  .spi_miso_oe_out        (spi_miso_oe_out),
  .turns_s_preset_out     (turns_s_preset_out),
  .turns_s_preset_stb_out (turns_s_preset_stb_out),
  .access_word_out        (access_word_out),
  .access_stb_out         (access_stb_out)
);
`default_nettype wire

/* verification/iamrb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host controller: serial master, mode 0, msb first
module iamrb_host_model (
  input  wire logic        miso_in,
  output var  logic        sck_out,
  output var  logic        cs_n_out,
  output var  logic        mosi_out,
  output var  logic        done_out,
  output var  logic [31:0] rx_out
);
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    done_out = 1'b0;
    rx_out   = 32'h0000_0000;
  end
  // one frame of n bits; clock stands low between frames
  task automatic frame(input logic [31:0] w, input int n);
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_out = w[31-i];
      #32 sck_out = 1'b1;
      rx_out = {rx_out[30:0], miso_in};
      #32 sck_out = 1'b0;
    end
    #32 cs_n_out = 1'b1;
    // released data line must not keep its last value
    mosi_out = ~mosi_out;
    done_out = 1'b1;
    // gap well above the four-cycle minimum
    #40 done_out = 1'b0;
  endtask
endmodule // iamrb_host_model
`default_nettype wire

/* verification/iamrb_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the register bank
module iamrb_top_tb;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [15:0] sin_s = 16'h0000, cos_s = 16'h0000, sin_p = 16'h0000;
  logic [15:0] prim = 16'h0000, sec = 16'h0000;
  logic [15:0] tp = 16'h0000, ts = 16'h0000;
  logic [11:0] temp = 12'h000;
  wire         sck, cs_n, mosi, miso, oe, done_w, p_stb, a_stb;
  wire         miso_d; // reply bit as the design drives it
  wire  [15:0] p_word, a_word;
  wire  [31:0] rx_w;
  int          miscompares = 0;
  int          comparisons = 0;
  logic [31:0] lfsr = 32'h0000_924a;
  logic [16:0] expq[$];   // {compare, value} per frame reply
  logic [31:0] rep;
  logic [15:0] v, hi, lo, s0, t0, u0;
  logic [7:0]  tgt[5] = '{8'h3f, 8'h40, 8'h7f, 8'h80, 8'h9e};
  always #2.5 clk_sys_in = ~clk_sys_in;
  // released reply line shows the inverse of its last bit
  assign miso = oe ? miso_d : ~miso_d;
  // ==========================================================
  // design and host
  iamrb_top #(.EE_WR_CYC(21'h00_07d0)) iamrb_top_i (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .spi_sck_in(sck), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
    .spi_miso_out(miso_d), .spi_miso_oe_out(oe),
    .sin_s_in(sin_s), .cos_s_in(cos_s), .temp_s_in(temp),
    .sin_p_in(sin_p), .prim_angle_in(prim), .secondary_angle_out_in(sec),
    .turns_p_in(tp), .turns_s_in(ts),
    .turns_s_preset_out(p_word), .turns_s_preset_stb_out(p_stb),
    .access_word_out(a_word), .access_stb_out(a_stb));
  iamrb_host_model iamrb_host_model_i (.miso_in(miso), .sck_out(sck),
    .cs_n_out(cs_n), .mosi_out(mosi), .done_out(done_w), .rx_out(rx_w));
  // ==========================================================
  // helpers
  task automatic rnd(output logic [15:0] r);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    r = lfsr[15:0];
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [31:0] w, input logic c,
                      input logic [15:0] e, input int n = 32);
    expq.push_back({c, e});
    iamrb_host_model_i.frame(w, n);
    rep = rx_w;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    xfer({2'b10, a, 8'h00, d}, 1'b0, 16'h0000);
  endtask
  // reply of a read arrives in the following frame
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    xfer({2'b00, a, 24'h00_0000}, 1'b0, 16'h0000);
    xfer(32'h0000_0000, 1'b1, e);
  endtask
  // status poll, bounded; done status is exactly bit 0
  task automatic poll(input logic [5:0] a);
    rep = 32'h0000_0000;
    for (int i = 0; i < 40 && rep[0] !== 1'b1; i++)
      xfer({2'b00, a, 24'h00_0000}, 1'b0, 16'h0000);
    check(rep, 32'h0000_0001);
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // reply watcher: oldest note against each finished frame
  always @(posedge done_w) begin : watch
    logic [16:0] e;
    e = expq.pop_front();
    if (e[16]) check(rx_w, {16'h0000, e[15:0]});
  end
  // watchdog, a fifth above the expected run, inside the budget
  initial begin
    #480_000;
    miscompares++;
    results();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    for (int a = 1; a <= 8; a++) rd(6'(a), 16'h0000);
    wr(6'h00, 16'hffff);
    rd(6'h00, 16'h0000);
    $display("reset and null register done");
    rnd(v);
    wr(6'h1f, v);
    xfer({2'b10, 6'h1f, 8'h00, ~v}, 1'b0, 16'h0000, 16);
    rd(6'h1f, v);
    wr(6'h1e, v);
    check({16'h0000, a_word}, {16'h0000, v});
    rd(6'h1e, 16'h0000);
    rd(6'h11, 16'h0000);
    wr(6'h1c, ~v);
    check({16'h0000, p_word}, {16'h0000, ~v});
    $display("echo access preset done");
    foreach (tgt[k]) begin
      rnd(hi);
      rnd(lo);
      wr(6'h01, {8'ha5, tgt[k]});
      rd(6'h01, {8'h00, tgt[k]});
      wr(6'h02, hi);
      wr(6'h03, lo);
      rd(6'h02, hi);
      wr(6'h04, 16'h8000);
      if (tgt[k] <= 8'h3f) rd(6'h04, 16'h0100);
      poll(6'h04);
      wr(6'h05, {8'h5a, tgt[k]});
      rd(6'h05, {8'h00, tgt[k]});
      wr(6'h06, 16'h8000);
      poll(6'h06);
      rd(6'h07, hi);
      rd(6'h08, lo);
      wr(6'h02, ~hi);
      wr(6'h04, 16'h8000);
      poll(6'h04);
      rd(6'h07, hi);
    end
    // read data register ignores a host write
    wr(6'h07, ~hi);
    rd(6'h07, hi);
    $display("extended access done");
    @(negedge clk_sys_in);
    rnd(sin_s);
    rnd(cos_s);
    rnd(sin_p);
    rnd(v);
    temp = v[11:0];
    rd(6'h09, sin_s);
    rd(6'h0a, cos_s);
    rd(6'h0c, sin_p);
    rd(6'h0b, {4'h0, temp});
    $display("samples done");
    @(negedge clk_sys_in);
    rnd(prim);
    rnd(sec);
    rnd(v);
    tp = v & 16'h07ff;
    ts = ~v & 16'h07ff;
    s0 = sec;
    t0 = tp;
    u0 = ts;
    rd(6'h10, prim);
    @(negedge clk_sys_in);
    sec = ~sec;
    tp = ~tp & 16'h07ff;
    ts = ~ts & 16'h07ff;
    rd(6'h1a, s0);
    rd(6'h1b, t0);
    rd(6'h1d, u0);
    rd(6'h19, sec);
    rd(6'h1c, ts);
    $display("snapshot done");
    results();
  end
endmodule // iamrb_top_tb
`default_nettype wire
